/* hw/tsm_pkg.sv */
// Constants and carrier types for the timeslot switch map block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and a 10 MHz system clock.
package tsm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          ADDR_W        = 9;
  localparam int          DATA_W        = 32;
  localparam int          BE_W          = 4;

  // Register byte offsets
  localparam logic [8:0]  OFF_TX_HOLD_A = 9'h1c0;
  localparam logic [8:0]  OFF_TX_HOLD_B = 9'h1c4;
  localparam logic [8:0]  OFF_RX_HOLD_A = 9'h1c8;
  localparam logic [8:0]  OFF_RX_HOLD_B = 9'h1cc;
  localparam logic [8:0]  OFF_STATUS    = 9'h1d4;
  localparam logic [8:0]  OFF_CTRL      = 9'h1d8;
  localparam logic [8:0]  OFF_LANE_EN   = 9'h1dc;
  localparam logic [8:0]  OFF_RX_MAP_A  = 9'h1e0;
  localparam logic [8:0]  OFF_RX_MAP_B  = 9'h1e4;
  localparam logic [8:0]  OFF_TX_MAP_A  = 9'h1e8;
  localparam logic [8:0]  OFF_TX_MAP_B  = 9'h1ec;

  ////////////////////////////////////////////////////////////////////////////////
  // Field layout
  localparam int          LANES         = 8;   // A0..A3 then B0..B3
  localparam int          LANES_PER_REG = 4;
  localparam int          TX_EN_LSB     = 24;
  localparam int          RX_EN_LSB     = 16;
  localparam int          SEL_W         = 5;
  localparam int          BYTE_W        = 8;
  localparam int          SLOT_W        = 7;
  localparam int          BIT_W         = 3;
  localparam int          CNT_W         = 5;
  localparam int          STAT_BIT_LSB  = 0;
  localparam int          STAT_SLOT_LSB = 8;

  localparam logic [BIT_W-1:0]  BIT_FIRST = 3'h0;
  localparam logic [BIT_W-1:0]  BIT_LAST  = 3'h7;
  localparam logic [SLOT_W-1:0] SLOT_ONE  = 7'h01;
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 7'h00;
  localparam logic [SLOT_W-1:0] SLOT_MAX  = 7'h7f;

  // Reset values
  localparam logic [15:0]       LANE_EN_RST = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RST     = 5'h00;
  localparam logic [BYTE_W-1:0] BYTE_RST    = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO   = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [LANES_PER_REG-1:0][SEL_W-1:0] sel;   // Byte 3..0 timeslot pointers
  } tsm_slot_map_t;

  typedef struct packed {
    logic [LANES-1:0] tx;                       // Transmit lane enables
    logic [LANES-1:0] rx;                       // Receive lane enables
  } tsm_lane_en_t;

  localparam tsm_slot_map_t MAP_RST = '0;

endpackage : tsm_pkg

/* hw/tsm_switch_map.sv */
// Timeslot switch map for a TDM serial highway, with Avalon-MM register access.
// Assumes link clock, frame sync and receive data arrive unsynchronised on pins.
`timescale 1ns/100ps
module tsm_switch_map
  import tsm_pkg::*;
(
  input  wire logic              clk,               // System clock, 10 MHz
  input  wire logic              sys_rst,           // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] avs_address,       // Byte address
  input  wire logic              avs_read,          // Read request
  input  wire logic              avs_write,         // Write request
  input  wire logic [DATA_W-1:0] avs_writedata,     // Write data
  input  wire logic [BE_W-1:0]   avs_byteenable,    // Write byte lanes
  output logic      [DATA_W-1:0] avs_readdata,      // Read data
  output logic                   avs_waitrequest,   // Stall, low for one cycle to answer
  input  wire logic              tdm_clk,           // Highway bit clock pin
  input  wire logic              tdm_fs,            // Frame sync pin, active high
  input  wire logic              tdm_din,           // Serial receive data pin
  output logic                   tdm_dout,          // Serial transmit data
  output logic                   tdm_dout_oe        // Transmit drive enable
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic                          wait_reg;
  logic [DATA_W-1:0]             rdata_reg;
  tsm_lane_en_t                  lane_en_reg;
  logic [15:0]                   lane_low_reg;
  tsm_slot_map_t                 rx_map_a_reg;
  tsm_slot_map_t                 rx_map_b_reg;
  tsm_slot_map_t                 tx_map_a_reg;
  tsm_slot_map_t                 tx_map_b_reg;
  logic [CNT_W-1:0]              slots_per_half_frame_m1;
  logic [LANES-1:0][BYTE_W-1:0]  tx_hold_reg;
  logic [LANES-1:0][BYTE_W-1:0]  rx_hold_reg;
  logic [BYTE_W-2:0]             shift_reg;
  logic [BIT_W-1:0]              bit_reg;
  logic [SLOT_W-1:0]             slot_reg;
  logic                          dout_reg;
  logic                          oe_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic link_rise;
  logic link_fall;
  logic fs_lvl;
  logic din_lvl;

  tsm_sync3 u_sync_clk (.clk(clk), .sys_rst(sys_rst), .async_in(tdm_clk),
                        .lvl(), .rise(link_rise), .fall(link_fall));
  tsm_sync3 u_sync_fs  (.clk(clk), .sys_rst(sys_rst), .async_in(tdm_fs),
                        .lvl(fs_lvl), .rise(), .fall());
  tsm_sync3 u_sync_din (.clk(clk), .sys_rst(sys_rst), .async_in(tdm_din),
                        .lvl(din_lvl), .rise(), .fall());

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire bus_req    = avs_read | avs_write;
  wire accept     = bus_req & ~wait_reg;
  // A write lands only at the edge where the master samples waitrequest low
  wire wr_go      = accept & avs_write;
  wire wr_lane_en = wr_go & (avs_address == OFF_LANE_EN);
  wire wr_rx_a    = wr_go & (avs_address == OFF_RX_MAP_A);
  wire wr_rx_b    = wr_go & (avs_address == OFF_RX_MAP_B);
  wire wr_tx_a    = wr_go & (avs_address == OFF_TX_MAP_A);
  wire wr_tx_b    = wr_go & (avs_address == OFF_TX_MAP_B);
  wire wr_ctrl    = wr_go & (avs_address == OFF_CTRL);
  wire wr_hold_a  = wr_go & (avs_address == OFF_TX_HOLD_A);
  wire wr_hold_b  = wr_go & (avs_address == OFF_TX_HOLD_B);

  // Merge a pointer word into a map under byte enables
  function automatic tsm_slot_map_t map_merge(input tsm_slot_map_t old_map,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [BE_W-1:0] be);
    tsm_slot_map_t m;
    m = old_map;
    for (int k = 0; k < LANES_PER_REG; k++) begin
      if (be[k]) begin
        m.sel[k] = wd[k*BYTE_W +: SEL_W];
      end
    end
    return m;
  endfunction : map_merge

  // Merge a full word under byte enables
  function automatic logic [DATA_W-1:0] word_merge(input logic [DATA_W-1:0] old_w,
                                                   input logic [DATA_W-1:0] wd,
                                                   input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] w;
    w = old_w;
    for (int k = 0; k < BE_W; k++) begin
      if (be[k]) begin
        w[k*BYTE_W +: BYTE_W] = wd[k*BYTE_W +: BYTE_W];
      end
    end
    return w;
  endfunction : word_merge

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; write-only and unmapped addresses read zero
  wire [DATA_W-1:0] lane_en_word = {lane_en_reg.tx, lane_en_reg.rx, lane_low_reg};
  wire [DATA_W-1:0] status_word  = (DATA_W'(slot_reg) << STAT_SLOT_LSB) |
                                   (DATA_W'(bit_reg) << STAT_BIT_LSB);
  wire [DATA_W-1:0] ctrl_word    = DATA_W'(slots_per_half_frame_m1);
  wire [DATA_W-1:0] rx_a_word    = rx_hold_reg[LANES_PER_REG-1:0];
  wire [DATA_W-1:0] rx_b_word    = rx_hold_reg[LANES-1:LANES_PER_REG];
  wire [DATA_W-1:0] tx_a_word    = tx_hold_reg[LANES_PER_REG-1:0];
  wire [DATA_W-1:0] tx_b_word    = tx_hold_reg[LANES-1:LANES_PER_REG];
  wire [DATA_W-1:0] rd_mux       = (avs_address == OFF_LANE_EN)   ? lane_en_word :
                                   (avs_address == OFF_STATUS)    ? status_word  :
                                   (avs_address == OFF_CTRL)      ? ctrl_word    :
                                   (avs_address == OFF_RX_HOLD_A) ? rx_a_word    :
                                   (avs_address == OFF_RX_HOLD_B) ? rx_b_word    : WORD_ZERO;

  // Handshake: waitrequest drops for one cycle after a request appears
  // Read data is loaded with the request, so it stands while waitrequest is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= WORD_ZERO;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
      if (avs_read & wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {lane_en_reg, lane_low_reg} <= {LANE_EN_RST, LANE_EN_RST};
      rx_map_a_reg                <= MAP_RST;
      rx_map_b_reg                <= MAP_RST;
      tx_map_a_reg                <= MAP_RST;
      tx_map_b_reg                <= MAP_RST;
      slots_per_half_frame_m1     <= CNT_RST;
    end else begin
      if (wr_lane_en) begin
        {lane_en_reg, lane_low_reg} <= word_merge(lane_en_word, avs_writedata, avs_byteenable);
      end
      if (wr_rx_a) rx_map_a_reg <= map_merge(rx_map_a_reg, avs_writedata, avs_byteenable);
      if (wr_rx_b) rx_map_b_reg <= map_merge(rx_map_b_reg, avs_writedata, avs_byteenable);
      if (wr_tx_a) tx_map_a_reg <= map_merge(tx_map_a_reg, avs_writedata, avs_byteenable);
      if (wr_tx_b) tx_map_b_reg <= map_merge(tx_map_b_reg, avs_writedata, avs_byteenable);
      if (wr_ctrl & avs_byteenable[0]) begin
        slots_per_half_frame_m1 <= avs_writedata[CNT_W-1:0];
      end
    end
  end

  // Transmit holding bytes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_hold_reg <= '0;
    end else begin
      if (wr_hold_a) tx_hold_reg[LANES_PER_REG-1:0] <= word_merge(tx_a_word, avs_writedata, avs_byteenable);
      if (wr_hold_b) tx_hold_reg[LANES-1:LANES_PER_REG] <= word_merge(tx_b_word, avs_writedata, avs_byteenable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slot position at the sampling edge; frame sync restarts slot 0 bit 0
  wire [BIT_W-1:0]  cur_bit   = fs_lvl ? BIT_FIRST : bit_reg;
  wire [SLOT_W-1:0] cur_slot  = fs_lvl ? SLOT_ZERO : slot_reg;
  wire              capture   = link_rise & (cur_bit == BIT_LAST);
  wire [BYTE_W-1:0] rx_byte   = {shift_reg, din_lvl};
  // B targets wrap modulo 128; software keeps B pointers inside the B range
  wire [SLOT_W-1:0] b_base    = SLOT_W'(slots_per_half_frame_m1) + SLOT_ONE;
  wire [SLOT_W-1:0] slot_step = (cur_slot == SLOT_MAX) ? cur_slot : cur_slot + SLOT_ONE;

  logic [LANES-1:0][SLOT_W-1:0] rx_target;
  logic [LANES-1:0][SLOT_W-1:0] tx_target;
  logic [LANES-1:0]             rx_hit;
  logic [LANES-1:0]             tx_hit;

  // Per-lane slot targets and hits
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    if (g < LANES_PER_REG) begin : g_a
      assign rx_target[g] = SLOT_W'(rx_map_a_reg.sel[g]);
      assign tx_target[g] = SLOT_W'(tx_map_a_reg.sel[g]);
    end else begin : g_b
      assign rx_target[g] = SLOT_W'(rx_map_b_reg.sel[g-LANES_PER_REG]) + b_base;
      assign tx_target[g] = SLOT_W'(tx_map_b_reg.sel[g-LANES_PER_REG]) + b_base;
    end
    assign rx_hit[g] = lane_en_reg.rx[g] & (cur_slot == rx_target[g]);
    assign tx_hit[g] = lane_en_reg.tx[g] & (slot_reg == tx_target[g]);
  end

  // Transmit byte select; lowest lane wins if two pointers collide
  // Disabled lanes never win, so an all-off map leaves the line undriven
  logic [BYTE_W-1:0] tx_byte;
  logic              tx_any;
  always_comb begin
    tx_byte = BYTE_RST;
    tx_any  = 1'b0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (tx_hit[i]) begin
        tx_byte = tx_hold_reg[i];
        tx_any  = 1'b1;
      end
    end
  end

  // Receive shifter, bit and slot counters on the link rising edge
  // Without frame sync the slot counter saturates instead of wrapping
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_reg <= '0;
      bit_reg   <= BIT_FIRST;
      slot_reg  <= SLOT_MAX;
    end else if (link_rise) begin
      shift_reg <= rx_byte[BYTE_W-2:0];
      bit_reg   <= cur_bit + 3'h1;
      if (cur_bit == BIT_LAST) begin
        slot_reg <= slot_step;
      end else begin
        slot_reg <= cur_slot;
      end
    end
  end

  // Captured bytes land only in enabled, matching lanes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_hold_reg <= '0;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        if (capture & rx_hit[i]) rx_hold_reg[i] <= rx_byte;
      end
    end
  end

  // Transmit bit driven MSB first on the link falling edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dout_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end else if (link_fall) begin
      dout_reg <= tx_any & tx_byte[BIT_LAST - bit_reg];
      oe_reg   <= tx_any;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;
  assign tdm_dout        = dout_reg;
  assign tdm_dout_oe     = oe_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_fall_hit;  link_fall & tx_any;   endsequence
  sequence s_fall_miss; link_fall & ~tx_any;  endsequence

  tx_lane_drive_a: assert property (s_fall_hit |=> tdm_dout_oe)
    else $error("enabled transmit lane not driven");
  tx_lane_quiet_a: assert property (s_fall_miss |=> !tdm_dout_oe && !tdm_dout)
    else $error("transmit driven with no enabled lane");
  rx_lane_cap_a: assert property (capture && rx_hit[0] |=> rx_hold_reg[0] == $past(rx_byte))
    else $error("enabled receive lane missed capture");
  rx_lane_hold_a: assert property (!(capture && rx_hit[4]) |=> $stable(rx_hold_reg[4]))
    else $error("receive lane changed without capture");
  map_field_load_a: assert property (wr_rx_a && avs_byteenable[3] |=> rx_map_a_reg.sel[3] == $past(avs_writedata[28:24]))
    else $error("pointer field not loaded");
  a_range_abs_a: assert property (rx_hit[1] |-> cur_slot == SLOT_W'(rx_map_a_reg.sel[1]))
    else $error("register A pointer not absolute");
  b_range_rel_a: assert property (rx_hit[5] |-> cur_slot > SLOT_W'(slots_per_half_frame_m1))
    else $error("register B lane hit below its range");
  count_load_a: assert property (wr_ctrl && avs_byteenable[0] |=> slots_per_half_frame_m1 == $past(avs_writedata[4:0]))
    else $error("channel count not loaded");
  tx_bit_order_a: assert property (link_fall && tx_hit[0] |=> tdm_dout == $past(tx_hold_reg[0][BIT_LAST - bit_reg]))
    else $error("transmit bit not from lane byte");
  bus_answer_a: assert property (bus_req && wait_reg |=> !wait_reg ##1 wait_reg)
    else $error("bus answer not one cycle");

  // Steps of the enable and pointer loads, and of an all-off transmit bit
  sequence s_tx_wr;      wr_lane_en & avs_byteenable[3];  endsequence
  sequence s_rx_wr;      wr_lane_en & avs_byteenable[2];  endsequence
  sequence s_b_wr;       wr_rx_b & avs_byteenable[0];     endsequence
  sequence s_tx_all_off; link_fall & ~|lane_en_reg.tx;    endsequence

  // Enable fields land at their own bit positions
  tx_en_load_a: assert property (s_tx_wr |=> lane_en_reg.tx == $past(avs_writedata[DATA_W-1:TX_EN_LSB]))
    else $error("transmit lane enables not loaded");
  rx_en_set_a: assert property (s_rx_wr |=> lane_en_reg.rx == $past(avs_writedata[TX_EN_LSB-1:RX_EN_LSB]))
    else $error("receive lane enables not loaded");
  // Register B pointer byte 0 lands in its 5-bit field
  b_map_load_a: assert property (s_b_wr |=> rx_map_b_reg.sel[0] == $past(avs_writedata[SEL_W-1:0]))
    else $error("register B pointer not loaded");
  // With every transmit lane off the line stays undriven
  tx_all_off_a: assert property (s_tx_all_off |=> !tdm_dout_oe)
    else $error("transmit driven with every lane off");
  // Read answer carries the word addressed when the request arrived
  read_data_a: assert property (avs_read && wait_reg |=> avs_readdata == $past(rd_mux))
    else $error("read data not from addressed register");

endmodule : tsm_switch_map

/* hw/tsm_sync3.sv */
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes clk is the system clock; async_in is any level from outside its domain.
`timescale 1ns/100ps
module tsm_sync3 (
  input  wire logic clk,       // System clock
  input  wire logic sys_rst,   // Synchronous reset, active high
  input  wire logic async_in,  // Level from another domain
  output logic      lvl,       // Filtered level
  output logic      rise,      // One-cycle pulse on accepted rise
  output logic      fall       // One-cycle pulse on accepted fall
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;

  // Stage chain; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        lvl_reg <= s3_reg;
      end
    end
  end

  // A change counts once stages two and three agree
  assign lvl  = lvl_reg;
  assign rise = (s2_reg == s3_reg) & s3_reg & ~lvl_reg;
  assign fall = (s2_reg == s3_reg) & ~s3_reg & lvl_reg;

endmodule : tsm_sync3

/* verification/tsm_highway_model.sv */
// Far-side model of the TDM highway: link clock, frame sync, receive data.
// Assumes the bench calls frame() and reads the captured bytes afterwards.
`timescale 1ns/100ps
module tsm_highway_model (
  output logic      tdm_clk,     // Link bit clock, still outside frames
  output logic      tdm_fs,      // Frame sync, high for bit 0 of slot 0
  output logic      tdm_din,     // Data sent towards the block
  input  wire logic tdm_dout,    // Data sent by the block
  input  wire logic tdm_dout_oe  // Block drives tdm_dout
);
  logic [7:0] tx_byte [16];  // Byte sent in each slot
  logic [7:0] rx_byte [16];  // Byte seen in each slot
  logic [3:0] oe_cnt  [16];  // Bits of each slot with drive enabled

  ////////////////////////////////////////////////////////////////////////////////
  // Idle link levels
  initial begin
    tdm_clk = 1'b0;
    tdm_fs  = 1'b0;
    tdm_din = 1'b0;
  end

  // One frame, MSB first, 800 ns per bit; data changes mid low phase
  task automatic frame(input int nslots);
    // Start off the system clock edge so pin changes never race its sampling
    #30;
    for (int s = 0; s < nslots; s++) begin
      oe_cnt[s] = 4'h0;
      for (int b = 7; b >= 0; b--) begin
        #200 tdm_fs = (s == 0) && (b == 7);
        tdm_din = tx_byte[s][b];
        #200 tdm_clk = 1'b1;
        // Sample the block's bit just before the falling edge
        #400 rx_byte[s][b] = tdm_dout;
        if (tdm_dout_oe === 1'b1) oe_cnt[s] = oe_cnt[s] + 4'h1;
        tdm_clk = 1'b0;
      end
    end
    // Released data line shows the inverse of its last value
    #200 tdm_fs = 1'b0;
    tdm_din = ~tdm_din;
  endtask : frame
endmodule : tsm_highway_model

/* verification/tsm_switch_map_tb.sv */
// Self-checking bench for the timeslot switch map.
// Assumes 8 slots per frame (count 3) and the highway model on the serial side.
`timescale 1ns/100ps
module tsm_switch_map_tb;
  import tsm_pkg::*;

  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [BE_W-1:0]   avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              tdm_clk;
  logic              tdm_fs;
  logic              tdm_din;
  logic              tdm_dout;
  logic              tdm_dout_oe;
  int                n_fail;
  int                total_checks;
  logic [DATA_W-1:0] rd;
  logic [7:0]        exp_tx [8];

  tsm_switch_map uut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tdm_clk(tdm_clk),
    .tdm_fs(tdm_fs), .tdm_din(tdm_din), .tdm_dout(tdm_dout), .tdm_dout_oe(tdm_dout_oe));

  tsm_highway_model far (
    .tdm_clk(tdm_clk), .tdm_fs(tdm_fs), .tdm_din(tdm_din), .tdm_dout(tdm_dout),
    .tdm_dout_oe(tdm_dout_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // System clock, 100 ns
  always #50 clk = ~clk;

  task results;
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask : check

  // Hold the request until waitrequest is sampled low, bounded
  task bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      $display("Error bus_wait expected answer seen none");
      n_fail++;
      results();
    end
  endtask : bus_wait

  task bus_write(input logic [8:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    bus_wait();
    avs_write      <= 1'b0;
  endtask : bus_write

  task bus_read(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read    <= 1'b0;
  endtask : bus_read

  // Compare what the far side saw in every slot
  task check_tx;
    for (int s = 0; s < 8; s++) begin
      check("tx_byte", {24'h0, far.rx_byte[s]}, {24'h0, exp_tx[s]});
      check("tx_oe_bits", {28'h0, far.oe_cnt[s]}, (exp_tx[s] != 8'h00) ? 32'h8 : 32'h0);
    end
  endtask : check_tx

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
    n_fail = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    // Reset values, write-only and unmapped reads
    bus_read(OFF_LANE_EN, rd);
    check("lane_en_rst", rd, 32'h0000_0000);
    bus_read(OFF_RX_MAP_A, rd);
    check("rx_map_a_rd", rd, 32'h0000_0000);
    bus_read(9'h1f0, rd);
    check("unmapped_rd", rd, 32'h0000_0000);
    // Byte lane write, then full storage of all 32 bits
    bus_write(OFF_LANE_EN, 32'hffff_ffff, 4'h2);
    bus_read(OFF_LANE_EN, rd);
    check("lane_en_be", rd, 32'h0000_ff00);
    bus_write(OFF_LANE_EN, 32'h77fb_a55a, 4'hf);
    bus_read(OFF_LANE_EN, rd);
    check("lane_en_rw", rd, 32'h77fb_a55a);
    // Four slots per half-frame: A holds 0..3, B holds 4..7
    bus_write(OFF_CTRL, 32'h0000_0003, 4'hf);
    bus_read(OFF_CTRL, rd);
    check("slot_count", rd, 32'h0000_0003);
    bus_write(OFF_RX_MAP_A, 32'h0300_0201, 4'hf);
    bus_write(OFF_RX_MAP_B, 32'h0201_0300, 4'hf);
    bus_write(OFF_TX_MAP_A, 32'h0003_0201, 4'hf);
    bus_write(OFF_TX_MAP_B, 32'h0302_0100, 4'hf);
    bus_write(OFF_TX_HOLD_A, 32'h4433_2211, 4'hf);
    bus_write(OFF_TX_HOLD_B, 32'h8877_6655, 4'hf);
    for (int k = 0; k < 8; k++) far.tx_byte[k] = 8'h81 + 8'h11 * 8'(k);
    exp_tx = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h55, 8'h66, 8'h77, 8'h00};
    // First frame settles the slot counter; judge the second
    far.frame(8);
    far.frame(8);
    repeat (20) @(posedge clk);
    bus_read(OFF_RX_HOLD_A, rd);
    check("rx_hold_a", rd, 32'hb400_a392);
    bus_read(OFF_RX_HOLD_B, rd);
    check("rx_hold_b", rd, 32'he7d6_f8c5);
    check_tx();
    // Eight slots seen since frame sync: counter at slot 8, bit 0
    bus_read(OFF_STATUS, rd);
    check("slot_status", rd, 32'h0000_0800);
    // All lanes off: nothing captured, nothing driven
    bus_write(OFF_LANE_EN, 32'h0000_0000, 4'hf);
    for (int k = 0; k < 8; k++) far.tx_byte[k] = 8'h3c ^ 8'(k);
    exp_tx = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    far.frame(8);
    repeat (20) @(posedge clk);
    bus_read(OFF_RX_HOLD_A, rd);
    check("rx_hold_a_off", rd, 32'hb400_a392);
    bus_read(OFF_RX_HOLD_B, rd);
    check("rx_hold_b_off", rd, 32'he7d6_f8c5);
    check_tx();
    results();
  end
endmodule : tsm_switch_map_tb
